// File: bpcs_cmd_status.sv
/*
  primary-side command and status registers of the express-to-pci bridge,
  with the enables they drive into the forwarding paths.
  assumes the configuration decoder gives 16-bit reads and writes at offsets
  04h and 06h and that event inputs are single-cycle pulses on clk_sys_i.
*/
module bpcs_cmd_status (
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  input  wire logic                    cfg_wr_i,
  input  wire logic                    cfg_rd_i,
  input  wire logic [7:0]              cfg_addr_i,
  input  wire logic [15:0]             cfg_wdata_i,
  output logic [15:0]                  cfg_rdata_o,
  input  wire bpcs_pkg::bpcs_event_type event_i,
  input  wire bpcs_pkg::bpcs_req_type   down_req_i,
  input  wire logic                    sec_req_i,
  input  wire logic                    sec_serr_i,
  output logic                         down_fwd_o,
  output logic                         down_ur_o,
  output logic                         promote_mwi_o,
  output logic                         bad_parity_o,
  output logic                         sec_respond_o,
  output logic                         up_req_o,
  output logic                         err_msg_allow_o,
  output logic                         signaled_system_error_flag_enable_o
);

  logic [15:0] cmd_reg;
  logic [15:0] rdata_reg;
  logic [15:0] sts_value;
  logic        sts_clr_wr;
  logic [7:0]  flags;
  logic [7:0]  flag_set;
  logic        parity_response_enable;
  logic        write_invalidate_promote_enable;
  logic        upstream_initiator_enable;
  logic        mem_space_decode_enable;
  logic        port_space_decode_enable;
  logic        system_error_report_enable;

  // only the documented read/write bits are stored; others stay zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmd_reg <= bpcs_pkg::CMD_RESET;
    end else if (cfg_wr_i && cfg_addr_i == bpcs_pkg::CMD_OFFSET) begin
      cmd_reg <= cfg_wdata_i & bpcs_pkg::CMD_RW_MASK;
    end
  end

  assign parity_response_enable          = cmd_reg[bpcs_pkg::CMD_PARITY_RESP_BIT];
  assign write_invalidate_promote_enable = cmd_reg[bpcs_pkg::CMD_PROMOTE_BIT];
  assign upstream_initiator_enable       = cmd_reg[bpcs_pkg::CMD_INITIATOR_BIT];
  assign mem_space_decode_enable         = cmd_reg[bpcs_pkg::CMD_MEM_SPACE_BIT];
  assign port_space_decode_enable        = cmd_reg[bpcs_pkg::CMD_PORT_SPACE_BIT];
  assign system_error_report_enable      = cmd_reg[bpcs_pkg::CMD_SIGNALED_SYSTEM_ERROR_FLAG_BIT];

  // downstream decode: a disabled space answers unsupported request
  logic req_hit;
  assign req_hit = (down_req_i.is_mem && mem_space_decode_enable)
                || (down_req_i.is_port && port_space_decode_enable);

  always_comb begin
    down_fwd_o = down_req_i.valid && req_hit;
    down_ur_o  = down_req_i.valid && !req_hit;
  end

  // promotion only applies to memory writes
  assign promote_mwi_o = down_fwd_o && down_req_i.is_mem && down_req_i.is_write
                      && write_invalidate_promote_enable;

  // poisoned payload always leaves with bad parity, no enable involved
  assign bad_parity_o = event_i.poisoned_tlp_rx;

  assign sec_respond_o    = upstream_initiator_enable;
  assign up_req_o         = sec_req_i && upstream_initiator_enable;
  assign err_msg_allow_o  = sec_serr_i && system_error_report_enable;
  assign signaled_system_error_flag_enable_o = system_error_report_enable;

  // sticky flags, index order: 0 parity, 1 sig ca, 2 rcv ca, 3 rcv ur, 4 signaled_system_error_flag, 5 poison
  assign flag_set[0] = parity_response_enable
                    && (event_i.poisoned_cpl_rx || event_i.write_poisoned);
  assign flag_set[1] = event_i.ca_completion_sent;
  assign flag_set[2] = event_i.cpl_ca_rx;
  assign flag_set[3] = event_i.cpl_ur_rx;
  assign flag_set[4] = event_i.err_msg_sent && system_error_report_enable;
  assign flag_set[5] = event_i.poisoned_tlp_rx;
  assign flag_set[7:6] = 2'b00;

  assign sts_clr_wr = cfg_wr_i && cfg_addr_i == bpcs_pkg::STS_OFFSET;

  localparam int FLAG_POS [6] = '{bpcs_pkg::STS_MASTER_PARITY_BIT, bpcs_pkg::STS_SIG_CA_BIT,
                                  bpcs_pkg::STS_RCV_CA_BIT, bpcs_pkg::STS_RCV_UR_BIT,
                                  bpcs_pkg::STS_SIG_SIGNALED_SYSTEM_ERROR_FLAG_BIT, bpcs_pkg::STS_POISON_BIT};

  for (genvar g = 0; g < 6; g++) begin : g_flag
    bpcs_sticky_bit u_flag (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .set_i     (flag_set[g]),
      .clear_i   (sts_clr_wr && cfg_wdata_i[FLAG_POS[g]]),
      .flag_o    (flags[g])
    );
  end
  assign flags[7:6] = 2'b00;

  // hardwired bits: all zero except the capability chain bit
  always_comb begin
    sts_value = bpcs_pkg::STS_RESET;
    sts_value[bpcs_pkg::STS_MASTER_PARITY_BIT] = flags[0];
    sts_value[bpcs_pkg::STS_SIG_CA_BIT]        = flags[1];
    sts_value[bpcs_pkg::STS_RCV_CA_BIT]        = flags[2];
    sts_value[bpcs_pkg::STS_RCV_UR_BIT]        = flags[3];
    sts_value[bpcs_pkg::STS_SIG_SIGNALED_SYSTEM_ERROR_FLAG_BIT]   = flags[4];
    sts_value[bpcs_pkg::STS_POISON_BIT]        = flags[5];
  end

  // registered read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_reg <= 16'h0000;
    end else if (cfg_rd_i) begin
      if (cfg_addr_i == bpcs_pkg::CMD_OFFSET) begin
        rdata_reg <= cmd_reg;
      end else if (cfg_addr_i == bpcs_pkg::STS_OFFSET) begin
        rdata_reg <= sts_value;
      end else begin
        rdata_reg <= 16'h0000;
      end
    end
  end

  assign cfg_rdata_o = rdata_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_cmd_ro_zero: assert property (cmd_reg[bpcs_pkg::CMD_PALETTE_BIT] == 1'b0
                                  && cmd_reg[bpcs_pkg::CMD_SPECIAL_BIT] == 1'b0)
    else $error("read-only command bits became set");
  a_parity_gate: assert property (!parity_response_enable && !flags[0]
                                  |=> !flags[0])
    else $error("master parity flag set while parity response disabled");
  a_parity_set: assert property (parity_response_enable && event_i.write_poisoned
                                 |=> flags[0])
    else $error("master parity flag missed a poisoned write");
  a_bad_parity: assert property (event_i.poisoned_tlp_rx |-> bad_parity_o)
    else $error("poisoned data not sent with bad parity");
  a_poison_flag: assert property (event_i.poisoned_tlp_rx ##1 1'b1 |-> sts_value[15])
    else $error("detected poison flag not set");
  a_signaled_system_error_flag: assert property (event_i.err_msg_sent && !system_error_report_enable
                              && !flags[4] |=> !flags[4])
    else $error("system error flag set without report enable");
  a_ur_answer: assert property (down_req_i.valid && down_req_i.is_mem && !down_req_i.is_port
                                && !mem_space_decode_enable |-> down_ur_o && !down_fwd_o)
    else $error("disabled memory request not answered unsupported");
  a_port_answer: assert property (down_req_i.valid && down_req_i.is_port && !down_req_i.is_mem
                                  && !port_space_decode_enable |-> down_ur_o)
    else $error("disabled port request not answered unsupported");
  a_no_upstream: assert property (!upstream_initiator_enable |-> !up_req_o && !sec_respond_o)
    else $error("upstream request while initiator disabled");
  a_set_wins: assert property (event_i.cpl_ur_rx && sts_clr_wr && cfg_wdata_i[13]
                               |=> flags[3])
    else $error("coincident clear lost an event");
  a_clear_one: assert property (sts_clr_wr && cfg_wdata_i[12] && !event_i.cpl_ca_rx
                                |=> !flags[2])
    else $error("write one did not clear completer abort flag");
  a_status_const: assert property (cfg_rd_i && cfg_addr_i == bpcs_pkg::STS_OFFSET
                                   |=> cfg_rdata_o[7:0] == 8'h10 && cfg_rdata_o[10:9] == 2'b00)
    else $error("hardwired status bits read wrong");
  a_promote: assert property (promote_mwi_o |-> write_invalidate_promote_enable)
    else $error("promotion while disabled");


  // reset is checked with its own disable so the reset cycle itself is covered
  a_reset_values: assert property (@(posedge clk_sys_i) disable iff (1'b0)
                                   srst_i
                                   |=> cmd_reg == bpcs_pkg::CMD_RESET && sts_value == bpcs_pkg::STS_RESET)
    else $error("registers not at reset values after reset");

  a_cmd_write: assert property (cfg_wr_i && cfg_addr_i == bpcs_pkg::CMD_OFFSET
                                |=> cmd_reg == ($past(cfg_wdata_i) & bpcs_pkg::CMD_RW_MASK))
    else $error("command write did not land");
  // outside reset, command only changes through a write at its own offset

  a_cmd_hold: assert property (!(cfg_wr_i && cfg_addr_i == bpcs_pkg::CMD_OFFSET)
                               |=> $stable(cmd_reg))
    else $error("command register changed without a write");

  a_cmd_read: assert property (cfg_rd_i && cfg_addr_i == bpcs_pkg::CMD_OFFSET
                               |=> cfg_rdata_o == $past(cmd_reg))
    else $error("command read returned wrong data");

  a_unmapped_read: assert property (cfg_rd_i && cfg_addr_i != bpcs_pkg::CMD_OFFSET
                                    && cfg_addr_i != bpcs_pkg::STS_OFFSET
                                    |=> cfg_rdata_o == 16'h0000)
    else $error("unmapped read returned nonzero");

  a_irq_zero: assert property (cfg_rd_i && cfg_addr_i == bpcs_pkg::STS_OFFSET
                               |=> cfg_rdata_o[3] == 1'b0 && cfg_rdata_o[4] == 1'b1)
    else $error("interrupt or capability bit read wrong");

  // each flag must catch its event in the next cycle, clear or not
  a_sig_ca_set: assert property (event_i.ca_completion_sent
                                 |=> flags[1])
    else $error("signaled completer abort flag missed");

  a_rcv_ca_set: assert property (event_i.cpl_ca_rx
                                 |=> flags[2])
    else $error("received completer abort flag missed");

  a_rcv_ur_set: assert property (event_i.cpl_ur_rx
                                 |=> flags[3])
    else $error("received unsupported flag missed");

  a_signaled_system_error_flag_set: assert property (event_i.err_msg_sent && system_error_report_enable
                                  |=> flags[4])
    else $error("system error flag missed");

  a_poison_cpl: assert property (parity_response_enable && event_i.poisoned_cpl_rx
                                 |=> flags[0])
    else $error("master parity flag missed a poisoned completion");

  a_flag_keep: assert property (!sts_clr_wr && flags[5]
                                |=> flags[5])
    else $error("poison flag dropped without a clear");

  a_zero_write: assert property (sts_clr_wr && !cfg_wdata_i[15] && flags[5]
                                 |=> flags[5])
    else $error("writing zero cleared the poison flag");

  // decode: an enabled space forwards, never both answers at once
  a_mem_fwd: assert property (down_req_i.valid && down_req_i.is_mem && mem_space_decode_enable
                              |-> down_fwd_o && !down_ur_o)
    else $error("enabled memory request not forwarded");

  a_port_fwd: assert property (down_req_i.valid && down_req_i.is_port && port_space_decode_enable
                               |-> down_fwd_o && !down_ur_o)
    else $error("enabled port request not forwarded");

  a_idle_quiet: assert property (!down_req_i.valid
                                 |-> !down_fwd_o && !down_ur_o && !promote_mwi_o)
    else $error("decode answered without a request");

  a_promote_need: assert property (down_req_i.valid && down_req_i.is_mem && down_req_i.is_write
                                   && mem_space_decode_enable && cmd_reg[bpcs_pkg::CMD_PROMOTE_BIT]
                                   |-> promote_mwi_o)
    else $error("enabled memory write not promoted");

  a_up_req: assert property (cmd_reg[bpcs_pkg::CMD_INITIATOR_BIT] && sec_req_i
                             |-> up_req_o && sec_respond_o)
    else $error("enabled upstream request not forwarded");

  a_err_allow: assert property (err_msg_allow_o
                                |-> cmd_reg[bpcs_pkg::CMD_SIGNALED_SYSTEM_ERROR_FLAG_BIT] && sec_serr_i)
    else $error("error message allowed while reporting disabled");

  a_no_bad_parity: assert property (!event_i.poisoned_tlp_rx
                                    |-> !bad_parity_o)
    else $error("bad parity without poisoned data");

  c_ur_answer: cover property (down_ur_o);
  c_promote:   cover property (promote_mwi_o);
  c_set_clear: cover property (event_i.cpl_ur_rx && sts_clr_wr);
  c_parity:    cover property (flags[0]);
  c_signaled_system_error_flag:   cover property (flags[4]);

endmodule : bpcs_cmd_status

// File: bpcs_pkg.sv
/*
  package for the bridge primary command and status block: register offsets,
  field positions, reset values, event and request carriers.
  assumes a single 250 MHz core clock and a synchronous active-high reset.
*/
package bpcs_pkg;

  localparam logic [7:0]  CMD_OFFSET      = 8'h04;
  localparam logic [7:0]  STS_OFFSET      = 8'h06;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [15:0] STS_RESET       = 16'h0010;

  // command field positions
  localparam int CMD_PORT_SPACE_BIT       = 0;
  localparam int CMD_MEM_SPACE_BIT        = 1;
  localparam int CMD_INITIATOR_BIT        = 2;
  localparam int CMD_SPECIAL_BIT          = 3;
  localparam int CMD_PROMOTE_BIT          = 4;
  localparam int CMD_PALETTE_BIT          = 5;
  localparam int CMD_PARITY_RESP_BIT      = 6;
  localparam int CMD_SIGNALED_SYSTEM_ERROR_FLAG_BIT          = 8;

  // status field positions
  localparam int STS_CAP_CHAIN_BIT        = 4;
  localparam int STS_MASTER_PARITY_BIT    = 8;
  localparam int STS_SIG_CA_BIT           = 11;
  localparam int STS_RCV_CA_BIT           = 12;
  localparam int STS_RCV_UR_BIT           = 13;
  localparam int STS_SIG_SIGNALED_SYSTEM_ERROR_FLAG_BIT      = 14;
  localparam int STS_POISON_BIT           = 15;

  // writable command bits and clearable status bits
  localparam logic [15:0] CMD_RW_MASK     = 16'h0157;
  localparam logic [15:0] STS_W1C_MASK    = 16'hF900;

  // events reported by the transaction paths, one-cycle pulses
  typedef struct packed {
    logic poisoned_tlp_rx;
    logic err_msg_sent;
    logic cpl_ur_rx;
    logic cpl_ca_rx;
    logic ca_completion_sent;
    logic poisoned_cpl_rx;
    logic write_poisoned;
  } bpcs_event_type;

  // downstream request class from the link receiver
  typedef struct packed {
    logic valid;
    logic is_mem;
    logic is_port;
    logic is_write;
  } bpcs_req_type;

endpackage : bpcs_pkg

// File: bpcs_sticky_bit.sv
/*
  one write-one-to-clear sticky status flag; any enable is applied to set_i outside this module.
  assumes set pulses and clear strobes are synchronous to clk_sys_i.
*/
module bpcs_sticky_bit (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_reg;
  logic flag_next;

  // set beats clear so a coincident event is never lost
  always_comb begin
    flag_next = flag_reg;
    if (clear_i) begin
      flag_next = 1'b0;
    end
    if (set_i) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule : bpcs_sticky_bit

// File: bpcs_link_model.sv
/*
  link-side partner: issues configuration requests and event pulses, each held one cycle, at most one every two cycles.
  assumes the dut samples everything on the rising edge of clk_sys_i.
*/
module bpcs_link_model (
  input  wire logic                    clk_sys_i,
  output logic                         cfg_wr_o,
  output logic                         cfg_rd_o,
  output logic [7:0]                   cfg_addr_o,
  output logic [15:0]                  cfg_wdata_o,
  output bpcs_pkg::bpcs_event_type     event_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cfg_wr_o    = 1'b0;
    cfg_rd_o    = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_wdata_o = 16'h0000;
    event_o     = '0;
  end

  // one strobe cycle, then released; stale address and data are inverted so they never look valid
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] addr, input logic [15:0] data,
                      input bpcs_pkg::bpcs_event_type ev);
    @(posedge clk_sys_i);
    #1;
    cfg_wr_o    = wr;
    cfg_rd_o    = rd;
    cfg_addr_o  = addr;
    cfg_wdata_o = data;
    event_o     = ev;
    @(posedge clk_sys_i);
    #1;
    cfg_wr_o    = 1'b0;
    cfg_rd_o    = 1'b0;
    cfg_addr_o  = ~addr;
    cfg_wdata_o = ~data;
    event_o     = '0;
  endtask : xfer
endmodule : bpcs_link_model

// File: testbench.sv
/*
  self-checking bench for the command and status registers.
  assumes the link model drives the config bus and events; the bench drives the request levels.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     clk_sys_i;
  logic                     srst_i;
  logic                     cfg_wr_i;
  logic                     cfg_rd_i;
  logic [7:0]               cfg_addr_i;
  logic [15:0]              cfg_wdata_i;
  logic [15:0]              cfg_rdata_o;
  bpcs_pkg::bpcs_event_type event_i;
  bpcs_pkg::bpcs_req_type   down_req_i;
  logic                     sec_req_i;
  logic                     sec_serr_i;
  logic                     down_fwd_o, down_ur_o, promote_mwi_o, bad_parity_o;
  logic                     sec_respond_o, up_req_o, err_msg_allow_o, signaled_system_error_flag_enable_o;
  int                       num_errors = 0;
  int                       n_checks = 0;

  bpcs_link_model lm (.clk_sys_i(clk_sys_i), .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i),
    .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i), .event_o(event_i));

  bpcs_cmd_status u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .event_i(event_i),
    .down_req_i(down_req_i), .sec_req_i(sec_req_i), .sec_serr_i(sec_serr_i), .down_fwd_o(down_fwd_o),
    .down_ur_o(down_ur_o), .promote_mwi_o(promote_mwi_o), .bad_parity_o(bad_parity_o),
    .sec_respond_o(sec_respond_o), .up_req_o(up_req_o), .err_msg_allow_o(err_msg_allow_o),
    .signaled_system_error_flag_enable_o(signaled_system_error_flag_enable_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    lm.xfer(1'b1, 1'b0, a, d, '0);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    lm.xfer(1'b0, 1'b1, a, 16'h0000, '0);
  endtask : rd

  task automatic t_reset_and_access;
    rd(8'h04);
    check(cfg_rdata_o, 16'h0000);
    rd(8'h06);
    check(cfg_rdata_o, 16'h0010);
    rd(8'h08);
    check(cfg_rdata_o, 16'h0000);
    wr(8'h04, 16'hFFFF);
    rd(8'h04);
    check(cfg_rdata_o, 16'h0157);
    wr(8'h06, 16'hFFFF);
    rd(8'h06);
    check(cfg_rdata_o, 16'h0010);
  endtask : t_reset_and_access

  // decode outputs are combinational, so they are sampled mid-cycle
  task automatic t_decode;
    logic [15:0] cmds [6];
    logic [15:0] c;
    cmds = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0012, 16'h0100};
    foreach (cmds[i]) begin
      c = cmds[i];
      wr(8'h04, c);
      #0.5;
      down_req_i = '{valid: 1'b1, is_mem: 1'b1, is_port: 1'b0, is_write: 1'b1};
      #0.5;
      check(16'({down_fwd_o, down_ur_o, promote_mwi_o}), 16'({c[1], ~c[1], c[1] & c[4]}));
      down_req_i = '{valid: 1'b1, is_mem: 1'b0, is_port: 1'b1, is_write: 1'b0};
      #0.5;
      check(16'({down_fwd_o, down_ur_o, promote_mwi_o}), 16'({c[0], ~c[0], 1'b0}));
      check(16'({sec_respond_o, up_req_o}), 16'({c[2], c[2]}));
      check(16'({err_msg_allow_o, signaled_system_error_flag_enable_o}), 16'({c[8], c[8]}));
      sec_req_i  = 1'b0;
      sec_serr_i = 1'b0;
      #0.5;
      check(16'({up_req_o, err_msg_allow_o}), 16'h0000);
      sec_req_i  = 1'b1;
      sec_serr_i = 1'b1;
      down_req_i = '0;
    end
  endtask : t_decode

  // each event alone, then all together with both enables off
  task automatic t_events;
    int bitpos [7];
    bpcs_pkg::bpcs_event_type ev;
    bitpos = '{8, 8, 11, 12, 13, 14, 15};
    wr(8'h04, 16'h0140);
    for (int i = 0; i < 7; i++) begin
      ev = 7'(1 << i);
      fork
        lm.xfer(1'b0, 1'b0, 8'h00, 16'h0000, ev);
        begin @(posedge clk_sys_i); #2; check(16'(bad_parity_o), 16'(ev[6])); end
      join
      rd(8'h06);
      check(cfg_rdata_o, 16'h0010 | (16'h0001 << bitpos[i]));
      wr(8'h06, 16'hFFFF);
    end
    wr(8'h04, 16'h0000);
    lm.xfer(1'b0, 1'b0, 8'h00, 16'h0000, 7'h7F);
    rd(8'h06);
    check(cfg_rdata_o, 16'hB810);
  endtask : t_events

  task automatic t_clear_race;
    wr(8'h06, 16'h0000);
    rd(8'h06);
    check(cfg_rdata_o, 16'hB810);
    lm.xfer(1'b1, 1'b0, 8'h06, 16'hFFFF, 7'h10);
    rd(8'h06);
    check(cfg_rdata_o, 16'h2010);
    wr(8'h06, 16'h2000);
    rd(8'h06);
    check(cfg_rdata_o, 16'h0010);
  endtask : t_clear_race

  // reset in mid-run must drop every enable and flag
  task automatic t_mid_reset;
    wr(8'h04, 16'h0157);
    lm.xfer(1'b0, 1'b0, 8'h00, 16'h0000, 7'h7F);
    rd(8'h06);
    check(cfg_rdata_o, 16'hF910);
    @(posedge clk_sys_i);
    #1;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    check(cfg_rdata_o, 16'h0000);
    check(16'({sec_respond_o, signaled_system_error_flag_enable_o}), 16'h0000);
    rd(8'h04);
    check(cfg_rdata_o, 16'h0000);
    rd(8'h06);
    check(cfg_rdata_o, 16'h0010);
  endtask : t_mid_reset

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #20000;
    num_errors++;
    final_report();
  end

  initial begin
    srst_i     = 1'b1;
    down_req_i = '0;
    sec_req_i  = 1'b1;
    sec_serr_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    t_reset_and_access();
    t_decode();
    t_events();
    t_clear_race();
    t_mid_reset();
    final_report();
  end
endmodule : testbench
